// >>> core/ccd_core.sv
`timescale 1ns/10ps
module ccd_core
    import ccd_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_resetn,
    input  wire logic [11:0] i_insn,
    input  wire logic        i_insn_valid,
    input  wire logic        i_prescaler_to_wdt,
    input  wire logic        i_wdt_tick,
    input  wire logic        i_pre_tick,
    output logic [7:0]       o_accumulator,
    output logic             o_zero_flag,
    output logic             o_timeout_status_bit,
    output logic             o_powerdown_status_bit,
    output logic [7:0]       o_watchdog_counter,
    output logic [7:0]       o_prescaler,
    output logic [4:0]       o_file_addr,
    output logic [7:0]       o_file_data
);
    op_t        op;
    logic       dest_file;
    logic [4:0] addr;

    ccd_decode u_dec (
        .i_word      (i_insn),
        .o_op        (op),
        .o_dest_file (dest_file),
        .o_addr      (addr)
    );

    logic [7:0] file_mem [NUM_FILES];
    logic [7:0] acc_ff;
    logic       zero_ff;
    logic       to_ff;
    logic       pd_ff;
    logic [7:0] wdt_ff;
    logic [7:0] pre_ff;
    logic [4:0] faddr_ff;
    logic [7:0] fdata_ff;

    wire        do_acc_clr = i_insn_valid && (op == OP_ACC_CLEAR);
    wire        do_wdt_clr = i_insn_valid && (op == OP_WDT_CLEAR);
    wire        do_alu     = i_insn_valid && (op == OP_INVERT || op == OP_DECR);
    wire [7:0]  operand    = file_mem[addr];
    wire [7:0]  inv_res    = ~operand;
    wire [7:0]  dec_res    = operand - ONE_BYTE;
    wire [7:0]  result     = (op == OP_INVERT) ? inv_res : dec_res;
    wire        res_zero   = (result == ZERO_BYTE);
    wire        wr_file    = do_alu && dest_file;
    wire        wr_acc     = do_alu && !dest_file;
    wire        clr_pre    = do_wdt_clr && i_prescaler_to_wdt;

    wire [7:0]  nxt_acc  = do_acc_clr ? ZERO_BYTE : (wr_acc ? result : acc_ff);
    wire        nxt_zero = do_acc_clr ? FLAG_ONE : (do_alu ? res_zero : zero_ff);
    wire [7:0]  nxt_wdt  = do_wdt_clr ? ZERO_BYTE : wdt_ff + WDT_W'(i_wdt_tick);
    wire [7:0]  nxt_pre  = clr_pre ? ZERO_BYTE : pre_ff + PRE_W'(i_pre_tick);

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            acc_ff   <= ACC_RESET;
            zero_ff  <= FLAG_ZERO;
            to_ff    <= FLAG_ONE;
            pd_ff    <= FLAG_ONE;
            wdt_ff   <= ZERO_BYTE;
            pre_ff   <= ZERO_BYTE;
            faddr_ff <= ADDR_RESET;
            fdata_ff <= ZERO_BYTE;
        end else begin
            acc_ff  <= nxt_acc;
            zero_ff <= nxt_zero;
            wdt_ff  <= nxt_wdt;
            pre_ff  <= nxt_pre;
            if (do_wdt_clr) begin
                to_ff <= FLAG_ONE;
                pd_ff <= FLAG_ONE;
            end
            if (wr_file) begin
                faddr_ff <= addr;
                fdata_ff <= result;
            end
        end
    end

    // one register per file address, all cleared at reset
    for (genvar g = 0; g < NUM_FILES; g++) begin : g_file
        wire hit = wr_file && (addr == ADDR_W'(g));
        always_ff @(posedge i_sys_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                file_mem[g] <= FILE_RESET;
            end else if (hit) begin
                file_mem[g] <= result;
            end
        end
    end

    assign o_accumulator          = acc_ff;
    assign o_zero_flag            = zero_ff;
    assign o_timeout_status_bit   = to_ff;
    assign o_powerdown_status_bit = pd_ff;
    assign o_watchdog_counter     = wdt_ff;
    assign o_prescaler            = pre_ff;
    assign o_file_addr            = faddr_ff;
    assign o_file_data            = fdata_ff;

    sequence s_acc_clr;
        i_insn_valid && i_insn == ACC_CLEAR_WORD;
    endsequence
    sequence s_wdt_clr;
        i_insn_valid && i_insn == WDT_CLEAR_WORD;
    endsequence
    sequence s_inv_file;
        i_insn_valid && i_insn[INSN_W-1:TOP_LSB] == INVERT_TOP && i_insn[DEST_BIT];
    endsequence
    sequence s_dec_acc;
        i_insn_valid && i_insn[INSN_W-1:TOP_LSB] == DECR_TOP && !i_insn[DEST_BIT];
    endsequence

    property p_acc_clear;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        s_acc_clr |=> (o_accumulator == ZERO_BYTE) && o_zero_flag;
    endproperty
    a_acc_clear: assert property (p_acc_clear) else $error("accumulator clear failed");

    property p_wdt_clear;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        s_wdt_clr |=> o_watchdog_counter == ZERO_BYTE;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared");

    property p_pre_clear;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        s_wdt_clr ##0 i_prescaler_to_wdt |=> o_prescaler == ZERO_BYTE;
    endproperty
    a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared");

    property p_pre_keep;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        s_wdt_clr ##0 !i_prescaler_to_wdt ##0 !i_pre_tick |=> $stable(o_prescaler);
    endproperty
    a_pre_keep: assert property (p_pre_keep) else $error("timer prescaler disturbed");

    property p_status_set;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        s_wdt_clr |=> o_timeout_status_bit && o_powerdown_status_bit;
    endproperty
    a_status_set: assert property (p_status_set) else $error("status bits not set");

    property p_invert_acc;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_insn_valid && i_insn[INSN_W-1:TOP_LSB] == INVERT_TOP && !i_insn[DEST_BIT]
        |=> o_accumulator == ~$past(operand);
    endproperty
    a_invert_acc: assert property (p_invert_acc) else $error("invert result wrong");

    property p_decr_file;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_insn_valid && i_insn[INSN_W-1:TOP_LSB] == DECR_TOP && i_insn[DEST_BIT]
        |=> o_file_data == $past(operand) - ONE_BYTE && $stable(o_accumulator);
    endproperty
    a_decr_file: assert property (p_decr_file) else $error("decrement write-back wrong");

    property p_zero_alu;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        do_alu |=> o_zero_flag == $past(res_zero) && $stable(o_timeout_status_bit);
    endproperty
    a_zero_alu: assert property (p_zero_alu) else $error("zero flag wrong");

    property p_dest_acc;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        wr_acc |=> $stable(o_file_data) && o_accumulator == $past(result);
    endproperty
    a_dest_acc: assert property (p_dest_acc) else $error("destination select wrong");

    property p_invert_file;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        s_inv_file |=> o_file_data == ~$past(operand) && $stable(o_accumulator);
    endproperty
    a_invert_file: assert property (p_invert_file) else $error("invert write-back wrong");

    property p_decr_acc;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        s_dec_acc |=> o_accumulator == $past(operand) - ONE_BYTE && $stable(o_file_data);
    endproperty
    a_decr_acc: assert property (p_decr_acc) else $error("decrement to accumulator wrong");

    property p_file_addr;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        wr_file |=> o_file_addr == $past(addr) && $stable(o_accumulator);
    endproperty
    a_file_addr: assert property (p_file_addr) else $error("write-back address wrong");

    property p_wdt_keep;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        s_wdt_clr |=> $stable(o_zero_flag) && $stable(o_accumulator);
    endproperty
    a_wdt_keep: assert property (p_wdt_keep) else $error("watchdog clear disturbed state");

    property p_alu_keep;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        do_alu |=> $stable(o_powerdown_status_bit);
    endproperty
    a_alu_keep: assert property (p_alu_keep) else $error("power-down bit disturbed");

    property p_acc_clr_keep;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        s_acc_clr |=> $stable(o_file_addr) && $stable(o_file_data);
    endproperty
    a_acc_clr_keep: assert property (p_acc_clr_keep) else $error("clear touched file");

    property p_invert_zero;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        s_inv_file ##0 (operand == ~ZERO_BYTE) |=> o_zero_flag && o_file_data == ZERO_BYTE;
    endproperty
    a_invert_zero: assert property (p_invert_zero) else $error("invert zero flag wrong");

    property p_decr_zero;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        s_dec_acc ##0 (operand == ONE_BYTE) |=> o_zero_flag && o_accumulator == ZERO_BYTE;
    endproperty
    a_decr_zero: assert property (p_decr_zero) else $error("decrement zero flag wrong");
endmodule

// >>> core/ccd_decode.sv
`timescale 1ns/10ps
module ccd_decode
    import ccd_pkg::*;
(
    input  wire logic [11:0] i_word,
    output op_t              o_op,
    output logic             o_dest_file,
    output logic [4:0]       o_addr
);
    wire is_acc_clr = (i_word == ACC_CLEAR_WORD);
    wire is_wdt_clr = (i_word == WDT_CLEAR_WORD);
    wire is_inv     = (i_word[INSN_W-1:TOP_LSB] == INVERT_TOP);
    wire is_dec     = (i_word[INSN_W-1:TOP_LSB] == DECR_TOP);

    assign o_op = is_acc_clr ? OP_ACC_CLEAR :
                  is_wdt_clr ? OP_WDT_CLEAR :
                  is_inv     ? OP_INVERT    :
                  is_dec     ? OP_DECR      : OP_NONE;
    assign o_dest_file = i_word[DEST_BIT];
    assign o_addr      = i_word[ADDR_W-1:0];
endmodule

// >>> core/ccd_pkg.sv
// Functional notes
// - exact accumulator_clear_op word: accumulator gets zero, zero flag set, one cycle.
// - exact watchdog_clear_op word: watchdog_counter cleared to zero within one cycle.
// - watchdog_clear_op clears prescaler only when prescaler is assigned to watchdog.
// - watchdog_clear_op sets timeout_status_bit and powerdown_status_bit to one.
// - file_invert_op: top six bits match, bit 5 destination, low five address; invert.
// - destination bit 0 writes accumulator, 1 writes back to addressed file register.
// - file_decrement_op: file register minus one modulo 256 to destination, no skip.
package ccd_pkg;
    localparam int          INSN_W        = 12;
    localparam int          DATA_W        = 8;
    localparam int          ADDR_W        = 5;
    localparam int          NUM_FILES     = 32;
    localparam int          WDT_W         = 8;
    localparam int          PRE_W         = 8;
    localparam int          DEST_BIT      = 5;
    localparam logic [11:0] ACC_CLEAR_WORD = 12'h040;
    localparam logic [11:0] WDT_CLEAR_WORD = 12'h004;
    localparam logic [5:0]  INVERT_TOP     = 6'h09;
    localparam logic [5:0]  DECR_TOP       = 6'h03;
    localparam logic [7:0]  ZERO_BYTE      = 8'h00;
    localparam logic [7:0]  ONE_BYTE       = 8'h01;
    localparam logic [7:0]  ACC_RESET      = 8'h00;
    localparam logic [7:0]  FILE_RESET     = 8'h00;
    localparam logic        FLAG_ONE       = 1'b1;
    localparam logic        FLAG_ZERO      = 1'b0;
    localparam logic [4:0]  ADDR_RESET     = 5'h00;
    localparam int          TOP_LSB        = 6;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_ACC_CLEAR,
        OP_WDT_CLEAR,
        OP_INVERT,
        OP_DECR
    } op_t;
endpackage

// >>> tb/clear_complement_decrement_ops_bench.sv
`timescale 1ns/10ps
module clear_complement_decrement_ops_bench
    import ccd_pkg::*;
;
    logic        i_sys_clk, i_resetn, wr, fetch, ps, wt, pt, insn_valid, zf, tof, pdf;
    logic [3:0]  wr_addr, pc;
    logic [11:0] wr_word, insn;
    logic [7:0]  acc, wdt, pre, fd, m_acc, m_wdt, m_pre, m_fd;
    logic [4:0]  fa, m_fa;
    logic        m_z, m_to, m_pd;
    logic [7:0]  mfile [32];
    logic [11:0] prog [16];
    logic [11:0] hand [16] = '{12'h040, 12'h004, 12'h041, 12'h265, 12'h0c5, 12'h245,
        12'h265, 12'h0e5, 12'h0e5, 12'h265, 12'h0c5, 12'h0e5, 12'h27f, 12'h0df, 12'h005,
        12'h004};
    int          fail_count, n_compared, k, j, s;

    prog_mem prog_mem_i (.i_sys_clk(i_sys_clk), .i_wr(wr), .i_wr_addr(wr_addr),
        .i_wr_word(wr_word), .i_fetch(fetch), .i_pc(pc), .o_insn(insn),
        .o_insn_valid(insn_valid));
    ccd_core ccd_core_i (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_insn(insn),
        .i_insn_valid(insn_valid), .i_prescaler_to_wdt(ps), .i_wdt_tick(wt),
        .i_pre_tick(pt), .o_accumulator(acc), .o_zero_flag(zf),
        .o_timeout_status_bit(tof), .o_powerdown_status_bit(pdf),
        .o_watchdog_counter(wdt), .o_prescaler(pre), .o_file_addr(fa), .o_file_data(fd));

    always #25 i_sys_clk = ~i_sys_clk;

    task chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e || $isunknown(g)) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask

    task cmp_all;
        chk(acc, m_acc);
        chk({7'h00, zf}, {7'h00, m_z});
        chk({6'h00, tof, pdf}, {6'h00, m_to, m_pd});
        chk(wdt, m_wdt);
        chk(pre, m_pre);
        chk({3'h0, fa}, {3'h0, m_fa});
        chk(fd, m_fd);
    endtask

    function automatic logic [11:0] rnd_word();
        logic [5:0] lo;
        lo = 6'($urandom);
        case ($urandom % 4)
            0: return {INVERT_TOP, lo};
            1: return {DECR_TOP, lo};
            2: return lo[0] ? ACC_CLEAR_WORD : WDT_CLEAR_WORD;
            default: return 12'($urandom);
        endcase
    endfunction

    task step(input logic [11:0] w);
        logic [7:0] r;
        if (wt) m_wdt = m_wdt + 8'h01;
        if (pt) m_pre = m_pre + 8'h01;
        if (w == ACC_CLEAR_WORD) begin
            m_acc = ZERO_BYTE;
            m_z = 1'b1;
        end else if (w == WDT_CLEAR_WORD) begin
            m_wdt = 8'h00;
            if (ps) m_pre = 8'h00;
            m_to = 1'b1;
            m_pd = 1'b1;
        end else if (w[11:6] == INVERT_TOP || w[11:6] == DECR_TOP) begin
            r = (w[11:6] == INVERT_TOP) ? ~mfile[w[4:0]] : mfile[w[4:0]] - 8'h01;
            m_z = (r == 8'h00);
            if (w[DEST_BIT]) begin
                mfile[w[4:0]] = r;
                m_fa = w[4:0];
                m_fd = r;
            end else m_acc = r;
        end
    endtask

    task reset_model;
        {m_acc, m_z, m_wdt, m_pre, m_fa, m_fd} = '0;
        {m_to, m_pd} = 2'b11;
        foreach (mfile[i]) mfile[i] = FILE_RESET;
    endtask

    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        {i_sys_clk, i_resetn, wr, fetch, ps, wt, pt, wr_addr, pc, wr_word} = '0;
        reset_model();
        fail_count = 0;
        n_compared = 0;
        s = $urandom(95);
        repeat (3) @(posedge i_sys_clk);
        @(negedge i_sys_clk) i_resetn = 1'b1;
        for (k = 0; k < 8; k++) begin
            if (k == 4) begin
                @(negedge i_sys_clk);
                cmp_all();
                {fetch, wt, pt, i_resetn} = 4'h0;
                reset_model();
                repeat (2) @(negedge i_sys_clk);
                i_resetn = 1'b1;
            end
            for (j = 0; j < 16; j++) begin
                @(negedge i_sys_clk);
                cmp_all();
                {fetch, wt, pt} = 3'b000;
                prog[j] = (k == 0) ? hand[j] : rnd_word();
                {wr, wr_addr, wr_word} = {1'b1, 4'(j), prog[j]};
            end
            for (j = 0; j < 16; j++) begin
                @(negedge i_sys_clk);
                cmp_all();
                {wr, fetch, pc} = {1'b0, 1'b1, 4'(j)};
                {ps, wt, pt} = 3'($urandom);
                step(prog[j]);
            end
        end
        @(negedge i_sys_clk);
        cmp_all();
        end_sim();
    end
endmodule

// >>> tb/prog_mem.sv
`timescale 1ns/10ps
module prog_mem (
    input  wire logic        i_sys_clk,
    input  wire logic        i_wr,
    input  wire logic [3:0]  i_wr_addr,
    input  wire logic [11:0] i_wr_word,
    input  wire logic        i_fetch,
    input  wire logic [3:0]  i_pc,
    output logic [11:0]      o_insn,
    output logic             o_insn_valid
);
    logic [11:0] rom [16];
    always @(posedge i_sys_clk) if (i_wr) rom[i_wr_addr] <= i_wr_word;
    // idle word is inverted; o_insn_valid follows i_fetch so a stale fetch never looks valid
    assign o_insn       = i_fetch ? rom[i_pc] : ~rom[i_pc];
    assign o_insn_valid = i_fetch;
endmodule
